//--- pcm_port_c.sv
// port c upper pin mux, direction, latch and analog select registers
`timescale 1ns/1ps
`include "pcm_cfg.svh"

module pcm_port_c #(
    parameter int ADDR_W = 5
) (
    input  wire logic                  sys_clk,
    input  wire logic                  rst_n,
    input  wire logic                  ce,
    input  wire logic [ADDR_W-1:0]     address,
    input  wire logic                  read,
    input  wire logic                  write,
    input  wire logic [31:0]           writedata,
    input  wire logic [3:0]            byteenable,
    output logic      [31:0]           readdata,
    output logic                       waitrequest,
    input  wire logic [7:0]            pin_in,
    output logic      [7:0]            pin_out,
    output logic      [7:0]            pin_oe,
    input  wire pcm_pkg::pcm_periph_in_t  periph_in,
    output pcm_pkg::pcm_periph_out_t      periph_out
);
    import pcm_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // elaboration checks

    // the map needs five address bits of bytes
    if (ADDR_W < 5) begin : g_addr_check
        $error("pcm_port_c: ADDR_W must be at least 5");
    end

    ////////////////////////////////////////////////////////////////////////
    // helper functions

    // byte address to register; unmapped gives PCM_REG_NONE
    function automatic pcm_reg_t reg_sel(input logic [ADDR_W-1:0] a);
        pcm_reg_t r;
        r = PCM_REG_NONE;
        if ((a >> 5) != '0) begin
            r = PCM_REG_NONE;
        end else if (a[4:0] == `PCM_OFF_PIN) begin
            r = PCM_REG_PIN;
        end else if (a[4:0] == `PCM_OFF_LATCH) begin
            r = PCM_REG_LATCH;
        end else if (a[4:0] == `PCM_OFF_DIR) begin
            r = PCM_REG_DIR;
        end else if (a[4:0] == `PCM_OFF_ANS_LO) begin
            r = PCM_REG_ANS_LO;
        end else if (a[4:0] == `PCM_OFF_ANS_HI) begin
            r = PCM_REG_ANS_HI;
        end
        return r;
    endfunction

    // pins whose digital input buffer is switched off
    function automatic logic [7:0] in_off(input logic [7:0] lo,
                                          input logic [7:0] hi,
                                          input logic       osc);
        logic [7:0] m;
        m = 8'h00;
        m[3:0] = lo[7:4];
        m[6]   = hi[`PCM_ANS_HI_PC6] | osc;
        m[7]   = hi[`PCM_ANS_HI_PC7] | osc;
        return m;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // state

    pcm_state_t st_reg;
    pcm_state_t st_next;
    pcm_reg_t   sel;
    logic [7:0] dig_in;
    logic       req;

    assign sel = reg_sel(address);
    assign req = read | write;

    // answer only on an enabled edge, so a frozen block never acks
    assign waitrequest = req & ~(st_reg.ack & ce);
    assign readdata    = {24'h000000, st_reg.rdata};
    assign pin_out     = st_reg.pin_out;
    assign pin_oe      = st_reg.pin_oe;
    assign periph_out  = st_reg.pout;

    // synchronised pins with analog or oscillator pins forced to zero
    assign dig_in = st_reg.sync2 & ~in_off(st_reg.ans_lo, st_reg.ans_hi,
                                           periph_in.t1_osc_en);

    ////////////////////////////////////////////////////////////////////////
    // next-state logic

    always_comb begin
        st_next = st_reg;
        if (ce) begin
            // two stages; the first is read only by the second
            st_next.sync1 = pin_in;
            st_next.sync2 = st_reg.sync1;

            // default: direction and latch, analog select ignored
            st_next.pin_oe  = ~st_reg.dir;
            st_next.pin_out = st_reg.latch;

            // bit 5: pwm channel a above compare output above latch
            if (!st_reg.dir[`PCM_BIT_PWM]) begin
                if (periph_in.pwm_a_en) begin
                    st_next.pin_out[`PCM_BIT_PWM] =
                        periph_in.pwm_a_out;
                    if (periph_in.pwm_shutdown
                        && periph_in.pwm_a_sd_float) begin
                        st_next.pin_oe[`PCM_BIT_PWM] = 1'b0;
                    end
                end else if (periph_in.ccp_out_en) begin
                    st_next.pin_out[`PCM_BIT_PWM] =
                        periph_in.ccp_out;
                end
            end

            // bit 7: spi data output over latch
            if (periph_in.spi_en && !st_reg.dir[`PCM_BIT_SDO]) begin
                st_next.pin_out[`PCM_BIT_SDO] = periph_in.spi_sdo;
            end

            // oscillator owns bits 6 and 7 whatever the direction says
            if (periph_in.t1_osc_en) begin
                st_next.pin_oe[7:6]  = 2'b00;
                st_next.pin_out[7:6] = 2'b00;
            end

            // inputs to peripherals only while the pin is an input
            st_next.pout.capture_in =
                st_reg.dir[`PCM_BIT_PWM] & dig_in[`PCM_BIT_PWM];
            st_next.pout.timer_zero_count_in =
                st_reg.dir[`PCM_BIT_PWM] & dig_in[`PCM_BIT_PWM];
            st_next.pout.ss_in =
                st_reg.dir[`PCM_BIT_SS] & dig_in[`PCM_BIT_SS];
            st_next.pout.timer_one_three_count_in =
                st_reg.dir[`PCM_BIT_SS] & dig_in[`PCM_BIT_SS];
            // analog routing needs an input pin not held by the oscillator
            st_next.pout.analog_channel_8 =
                st_reg.dir[6] & ~periph_in.t1_osc_en;
            st_next.pout.analog_channel_9 =
                st_reg.dir[7] & ~periph_in.t1_osc_en;
            st_next.pout.timer_one_osc_link = periph_in.t1_osc_en;
            st_next.pout.analog_sel_ra4 =
                st_reg.ans_lo[`PCM_ANS_LO_RA4];
            st_next.pout.analog_sel_rb = st_reg.ans_hi[3:2];

            // bus slave: one wait cycle, then the answer
            st_next.ack = 1'b0;
            if (req && !st_reg.ack) begin
                st_next.ack   = 1'b1;
                st_next.rdata = 8'h00;
                if (read) begin
                    case (sel)
                        PCM_REG_PIN:    st_next.rdata = dig_in;
                        PCM_REG_LATCH:  st_next.rdata = st_reg.latch;
                        PCM_REG_DIR:    st_next.rdata = st_reg.dir;
                        PCM_REG_ANS_LO: st_next.rdata =
                            st_reg.ans_lo & `PCM_ANS_LO_MASK;
                        PCM_REG_ANS_HI: st_next.rdata =
                            st_reg.ans_hi & `PCM_ANS_HI_MASK;
                        default:        st_next.rdata = 8'h00;
                    endcase
                end
            end

            // writes land at the edge where waitrequest is low
            if (write && st_reg.ack && byteenable[0]) begin
                case (sel)
                    // a write to the pin value goes to the latch
                    PCM_REG_PIN:    st_next.latch = writedata[7:0];
                    PCM_REG_LATCH:  st_next.latch = writedata[7:0];
                    PCM_REG_DIR:    st_next.dir   = writedata[7:0];
                    PCM_REG_ANS_LO: st_next.ans_lo =
                        writedata[7:0] & `PCM_ANS_LO_MASK;
                    PCM_REG_ANS_HI: st_next.ans_hi =
                        writedata[7:0] & `PCM_ANS_HI_MASK;
                    default:        st_next.ans_hi = st_reg.ans_hi;
                endcase
            end
        end
    end

    // register the whole state; pins start as inputs
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg        <= '0;
            st_reg.latch  <= `PCM_RST_LATCH;
            st_reg.dir    <= `PCM_RST_DIR;
            st_reg.ans_lo <= `PCM_RST_ANS_LO;
            st_reg.ans_hi <= `PCM_RST_ANS_HI;
        end else begin
            st_reg <= st_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // assertions

    property p_dir_out_drives_latch;
        @(posedge sys_clk) disable iff (!rst_n)
        ce && !st_reg.dir[2]
        |=> pin_oe[2] && pin_out[2] == $past(st_reg.latch[2]);
    endproperty
    a_dir_out_drives_latch: assert property (p_dir_out_drives_latch)
        else $error("output pin does not drive latch");

    property p_dir_input_floats;
        @(posedge sys_clk) disable iff (!rst_n)
        ce && st_reg.dir[4] |=> !pin_oe[4];
    endproperty
    a_dir_input_floats: assert property (p_dir_input_floats)
        else $error("input pin is driven");

    property p_ccp_drives_bit5;
        @(posedge sys_clk) disable iff (!rst_n)
        ce && periph_in.ccp_out_en && !periph_in.pwm_a_en && !st_reg.dir[5]
        |=> pin_oe[5] && pin_out[5] == $past(periph_in.ccp_out);
    endproperty
    a_ccp_drives_bit5: assert property (p_ccp_drives_bit5)
        else $error("compare output not on bit 5");

    property p_pwm_shutdown_float;
        @(posedge sys_clk) disable iff (!rst_n)
        ce && periph_in.pwm_a_en && periph_in.pwm_shutdown
        && periph_in.pwm_a_sd_float |=> !pin_oe[5];
    endproperty
    a_pwm_shutdown_float: assert property (p_pwm_shutdown_float)
        else $error("pwm channel a not floated in shutdown");

    property p_osc_frees_pins;
        @(posedge sys_clk) disable iff (!rst_n)
        ce && periph_in.t1_osc_en |=> pin_oe[7:6] == 2'b00
        && periph_out.timer_one_osc_link;
    endproperty
    a_osc_frees_pins: assert property (p_osc_frees_pins)
        else $error("oscillator pins still driven");

    property p_spi_drives_bit7;
        @(posedge sys_clk) disable iff (!rst_n)
        ce && periph_in.spi_en && !st_reg.dir[7] && !periph_in.t1_osc_en
        |=> pin_oe[7] && pin_out[7] == $past(periph_in.spi_sdo);
    endproperty
    a_spi_drives_bit7: assert property (p_spi_drives_bit7)
        else $error("spi data not on bit 7");

    property p_analog_read_zero;
        @(posedge sys_clk) disable iff (!rst_n)
        read && !waitrequest && sel == PCM_REG_PIN
        && st_reg.ans_hi[`PCM_ANS_HI_PC7] |-> readdata[7] == 1'b0;
    endproperty
    a_analog_read_zero: assert property (p_analog_read_zero)
        else $error("analog pin reads non-zero");

    property p_analog_keeps_output;
        @(posedge sys_clk) disable iff (!rst_n)
        ce && !st_reg.dir[0] && st_reg.ans_lo[4] |=> pin_oe[0];
    endproperty
    a_analog_keeps_output: assert property (p_analog_keeps_output)
        else $error("analog select blocked output");

    property p_unimpl_read_zero;
        @(posedge sys_clk) disable iff (!rst_n)
        read && !waitrequest && sel == PCM_REG_ANS_LO
        |-> readdata[2:0] == 3'h0;
    endproperty
    a_unimpl_read_zero: assert property (p_unimpl_read_zero)
        else $error("unimplemented bits read non-zero");

    // both stages must have left reset, or sync2 still holds zero
    property p_sync_two_stage;
        @(posedge sys_clk) disable iff (!rst_n)
        $past(rst_n) && $past(rst_n, 2) && $past(ce) && $past(ce, 2)
        |-> st_reg.sync2 == $past(pin_in, 2);
    endproperty
    a_sync_two_stage: assert property (p_sync_two_stage)
        else $error("synchroniser depth wrong");

    property p_pwm_drives_bit5;
        @(posedge sys_clk) disable iff (!rst_n)
        ce && periph_in.pwm_a_en && !periph_in.pwm_shutdown && !st_reg.dir[5]
        |=> pin_oe[5] && pin_out[5] == $past(periph_in.pwm_a_out);
    endproperty
    a_pwm_drives_bit5: assert property (p_pwm_drives_bit5)
        else $error("pwm channel a not on bit 5");

    property p_osc_reads_zero;
        @(posedge sys_clk) disable iff (!rst_n)
        ce && read && waitrequest && sel == PCM_REG_PIN && periph_in.t1_osc_en
        |=> readdata[7:6] == 2'b00;
    endproperty
    a_osc_reads_zero: assert property (p_osc_reads_zero)
        else $error("oscillator pins read non-zero");

    property p_ss_needs_input;
        @(posedge sys_clk) disable iff (!rst_n)
        ce && !st_reg.dir[6]
        |=> !periph_out.ss_in && !periph_out.timer_one_three_count_in;
    endproperty
    a_ss_needs_input: assert property (p_ss_needs_input)
        else $error("output pin feeds peripheral inputs");

    property p_analog_route;
        @(posedge sys_clk) disable iff (!rst_n)
        ce && !periph_in.t1_osc_en
        |=> periph_out.analog_channel_8 == $past(st_reg.dir[6])
        && periph_out.analog_channel_9 == $past(st_reg.dir[7]);
    endproperty
    a_analog_route: assert property (p_analog_route)
        else $error("analog channel routing wrong");

    property p_ans_lo_low_zero;
        @(posedge sys_clk) disable iff (!rst_n)
        st_reg.ans_lo[2:0] == 3'h0;
    endproperty
    a_ans_lo_low_zero: assert property (p_ans_lo_low_zero)
        else $error("unimplemented analog-select bits set");

    property p_write_lands_latch;
        @(posedge sys_clk) disable iff (!rst_n)
        write && !waitrequest && byteenable[0]
        && (sel == PCM_REG_PIN || sel == PCM_REG_LATCH)
        |=> st_reg.latch == $past(writedata[7:0]);
    endproperty
    a_write_lands_latch: assert property (p_write_lands_latch)
        else $error("latch write lost");

    property p_ans_hi_masked;
        @(posedge sys_clk) disable iff (!rst_n)
        write && !waitrequest && byteenable[0] && sel == PCM_REG_ANS_HI
        |=> st_reg.ans_hi == ($past(writedata[7:0]) & `PCM_ANS_HI_MASK);
    endproperty
    a_ans_hi_masked: assert property (p_ans_hi_masked)
        else $error("high analog-select write wrong");

    property p_pc0_analog_zero;
        @(posedge sys_clk) disable iff (!rst_n)
        read && !waitrequest && sel == PCM_REG_PIN && st_reg.ans_lo[4]
        |-> readdata[0] == 1'b0;
    endproperty
    a_pc0_analog_zero: assert property (p_pc0_analog_zero)
        else $error("analog pin 0 reads non-zero");

endmodule // pcm_port_c

//--- pcm_cfg.svh
// constants for the port c pin mux and analog select block
// Functional notes
// - direction bit one tri-states the pin; zero drives the latch bit
// - compare/pwm output drives bit 5 instead of latch when direction is zero
// - pwm channel a overrides latch on bit 5, may float during shutdown
// - bit 6 as input supplies serial slave-select through a ttl buffer
// - bit 6 as input feeds the shared timer one/three count input
// - timer one oscillator takes bits 6 and 7, killing all digital i/o
// - functions with don't-care direction ignore or override the direction bit
// - spi data output drives bit 7 when enabled and direction is zero
// - bits 6 and 7 route to analog channels 8 and 9 as inputs
// - analog-select set disables the input buffer; digital reads give zero
// - analog-select never blocks digital output on a pin
// - low analog-select bits 7..3 map to port c bits 3..0 and port a bit 4
// - low analog-select bits 2..0 ignore writes and read zero
// - high analog-select bits 1 and 0 gate port c bits 7 and 6
`ifndef PCM_CFG_SVH
`define PCM_CFG_SVH

// register byte offsets on the bus
`define PCM_OFF_PIN     5'h00
`define PCM_OFF_LATCH   5'h04
`define PCM_OFF_DIR     5'h08
`define PCM_OFF_ANS_LO  5'h0C
`define PCM_OFF_ANS_HI  5'h10

// reset values
`define PCM_RST_LATCH   8'h00
`define PCM_RST_DIR     8'hFF
`define PCM_RST_ANS_LO  8'hF8
`define PCM_RST_ANS_HI  8'h0F

// implemented bits of the analog-select registers
`define PCM_ANS_LO_MASK 8'hF8
`define PCM_ANS_HI_MASK 8'h0F

// field positions
`define PCM_BIT_PWM     5
`define PCM_BIT_SS      6
`define PCM_BIT_SDO     7
`define PCM_ANS_LO_RA4  3
`define PCM_ANS_HI_PC6  0
`define PCM_ANS_HI_PC7  1

// synchroniser depth in cycles of sys_clk
`define PCM_SYNC_STAGES 2

`endif

//--- pcm_pkg.sv
// types for the port c pin mux and analog select block
package pcm_pkg;

    // register selected by a bus address
    typedef enum logic [5:0] {
        PCM_REG_PIN    = 6'b000001,
        PCM_REG_LATCH  = 6'b000010,
        PCM_REG_DIR    = 6'b000100,
        PCM_REG_ANS_LO = 6'b001000,
        PCM_REG_ANS_HI = 6'b010000,
        PCM_REG_NONE   = 6'b100000
    } pcm_reg_t;

    // controls arriving from the peripherals that may own pins
    typedef struct packed {
        logic ccp_out_en;      // compare or pwm mode active
        logic ccp_out;         // capture_compare_io drive value
        logic pwm_a_en;        // enhanced_pwm_chan_a steered to bit 5
        logic pwm_a_out;
        logic pwm_shutdown;    // shutdown event in progress
        logic pwm_a_sd_float;  // float channel a during shutdown
        logic spi_en;          // serial port enabled in spi mode
        logic spi_sdo;
        logic t1_osc_en;       // timer one crystal oscillator on
    } pcm_periph_in_t;

    // signals handed from the pins to the peripherals
    typedef struct packed {
        logic       capture_in;               // capture_compare_io input
        logic       timer_zero_count_in;
        logic       ss_in;                    // slave select, ttl buffer
        logic       timer_one_three_count_in; // schmitt buffer
        logic       analog_channel_8;         // route bit 6 to converter
        logic       analog_channel_9;         // route bit 7 to converter
        logic       timer_one_osc_link;       // pins 6/7 given to oscillator
        logic       analog_sel_ra4;
        logic [1:0] analog_sel_rb;            // bits for port b 4 and 5
    } pcm_periph_out_t;

    // complete state of the block
    typedef struct packed {
        logic [7:0]      latch;
        logic [7:0]      dir;
        logic [7:0]      ans_lo;
        logic [7:0]      ans_hi;
        logic [7:0]      sync1;
        logic [7:0]      sync2;
        logic [7:0]      pin_out;
        logic [7:0]      pin_oe;
        pcm_periph_out_t pout;
        logic            ack;
        logic [7:0]      rdata;
    } pcm_state_t;

endpackage

//--- pcm_board_model.sv
// board-side model of the port c pins: pull-ups plus external drivers
`timescale 1ns/1ps

module pcm_board_model (
    input  wire logic [7:0] pin_out,
    input  wire logic [7:0] pin_oe,
    input  wire logic [7:0] ext_en,
    input  wire logic [7:0] ext_val,
    output logic      [7:0] pin_lvl
);

    // device drive wins, so contention never hides a wrong enable;
    // an undriven line floats to its pull-up instead of a stale value
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            pin_lvl[i] = pin_oe[i] ? pin_out[i]
                                   : (ext_en[i] ? ext_val[i] : 1'b1);
        end
    end

endmodule // pcm_board_model

//--- pcm_port_c_tb.sv
// self-checking bench for the port c pin mux and analog select block
`timescale 1ns/1ps
`include "pcm_cfg.svh"

module pcm_port_c_tb;
    import pcm_pkg::*;

    logic            sys_clk;
    logic            rst_n;
    logic            ce;
    logic            read;
    logic            write;
    logic [4:0]      address;
    logic [31:0]     writedata;
    logic [31:0]     readdata;
    logic [3:0]      byteenable;
    logic            waitrequest;
    logic [7:0]      pin_lvl;
    logic [7:0]      pin_out;
    logic [7:0]      pin_oe;
    logic [7:0]      ext_en;
    logic [7:0]      ext_val;
    pcm_periph_in_t  per_in;
    pcm_periph_out_t per_out;
    int              bad_count;
    int              n_compared;
    logic [31:0]     rd;

    ////////////////////////////////////////////////////////////////////////
    pcm_port_c #(.ADDR_W(5)) uut (
        .sys_clk    (sys_clk),
        .rst_n      (rst_n),
        .ce         (ce),
        .address    (address),
        .read       (read),
        .write      (write),
        .writedata  (writedata),
        .byteenable (byteenable),
        .readdata   (readdata),
        .waitrequest(waitrequest),
        .pin_in     (pin_lvl),
        .pin_out    (pin_out),
        .pin_oe     (pin_oe),
        .periph_in  (per_in),
        .periph_out (per_out)
    );

    pcm_board_model board (
        .pin_out(pin_out),
        .pin_oe (pin_oe),
        .ext_en (ext_en),
        .ext_val(ext_val),
        .pin_lvl(pin_lvl)
    );

    ////////////////////////////////////////////////////////////////////////
    // free-running 25 MHz system clock
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    // compare one value and count it
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // one avalon access: request raised just after an edge and held until
    // the rising edge where waitrequest is sampled low; data taken there
    task bus(input logic wr, input logic [4:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge sys_clk);
        read      <= ~wr;
        write     <= wr;
        address   <= a;
        writedata <= {24'h000000, d};
        do begin
            @(posedge sys_clk);
            n++;
        end while (waitrequest && n < 50);
        if (n >= 50) bad_count++;
        rd = readdata;
        read  <= 1'b0;
        write <= 1'b0;
    endtask

    task wr(input logic [4:0] a, input logic [7:0] d);
        bus(1'b1, a, d);
    endtask

    task rdc(input string nm, input logic [4:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00);
        chk(nm, rd, {24'h000000, e});
        // later checks then look at outputs away from the launching edge
        @(negedge sys_clk);
    endtask

    // let pin changes pass the synchroniser and output registers
    task settle;
        repeat (4) @(posedge sys_clk);
        @(negedge sys_clk);
    endtask

    task pins(input logic [7:0] oe, input logic [7:0] out);
        chk("pin_oe", {24'h000000, pin_oe}, {24'h000000, oe});
        chk("pin_out", {24'h000000, pin_out}, {24'h000000, out});
    endtask

    task complete_run;
        if (bad_count == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // watchdog: the whole sequence needs well under a thousand cycles
    initial begin
        repeat (20000) @(posedge sys_clk);
        bad_count++;
        complete_run;
    end

    // main sequence
    initial begin
        rst_n = 1'b0; ce = 1'b1; read = 1'b0; write = 1'b0;
        address = 5'h00; writedata = 32'h0; byteenable = 4'h1;
        per_in = '0; ext_en = 8'hFF; ext_val = 8'hE0;
        bad_count = 0; n_compared = 0;
        repeat (10) @(posedge sys_clk);
        rst_n <= 1'b1;
        // reset values, unmapped address and reserved bits
        rdc("latch", `PCM_OFF_LATCH, 8'h00);
        rdc("dir", `PCM_OFF_DIR, 8'hFF);
        rdc("ans_lo", `PCM_OFF_ANS_LO, 8'hF8);
        rdc("ans_hi", `PCM_OFF_ANS_HI, 8'h0F);
        rdc("unmapped", 5'h14, 8'h00);
        pins(8'h00, 8'h00);
        rdc("pin analog", `PCM_OFF_PIN, 8'h20);
        chk("sel_ra4", {31'h0, per_out.analog_sel_ra4}, 32'h1);
        chk("sel_rb", {30'h0, per_out.analog_sel_rb}, 32'h3);
        wr(`PCM_OFF_ANS_LO, 8'hFF);
        rdc("ans_lo ro", `PCM_OFF_ANS_LO, 8'hF8);
        wr(`PCM_OFF_ANS_HI, 8'hFF);
        rdc("ans_hi ro", `PCM_OFF_ANS_HI, 8'h0F);
        // analog bits cleared before the pins are read digitally
        wr(`PCM_OFF_ANS_HI, 8'h00);
        wr(`PCM_OFF_ANS_LO, 8'h00);
        ext_val <= 8'hE9;
        settle;
        rdc("pin digital", `PCM_OFF_PIN, 8'hE9);
        chk("ss_in", {31'h0, per_out.ss_in}, 32'h1);
        chk("t13", {31'h0, per_out.timer_one_three_count_in}, 32'h1);
        chk("capture", {31'h0, per_out.capture_in}, 32'h1);
        chk("t0 count", {31'h0, per_out.timer_zero_count_in}, 32'h1);
        chk("sel_rb off", {30'h0, per_out.analog_sel_rb}, 32'h0);
        chk("an8", {31'h0, per_out.analog_channel_8}, 32'h1);
        chk("an9", {31'h0, per_out.analog_channel_9}, 32'h1);
        chk("sel_ra4 off", {31'h0, per_out.analog_sel_ra4}, 32'h0);
        wr(`PCM_OFF_ANS_LO, 8'h98);
        settle;
        rdc("pin pc0 pc3 gated", `PCM_OFF_PIN, 8'hE0);
        chk("sel_ra4 on", {31'h0, per_out.analog_sel_ra4}, 32'h1);
        wr(`PCM_OFF_ANS_HI, 8'h02);
        settle;
        rdc("pin pc7 gated", `PCM_OFF_PIN, 8'h60);
        wr(`PCM_OFF_ANS_HI, 8'h00);
        // oscillator takes bits 6 and 7 whatever the direction
        per_in.t1_osc_en <= 1'b1;
        wr(`PCM_OFF_DIR, 8'h00);
        settle;
        pins(8'h3F, 8'h00);
        chk("osc link", {31'h0, per_out.timer_one_osc_link}, 32'h1);
        chk("an8 osc", {31'h0, per_out.analog_channel_8}, 32'h0);
        rdc("pin osc", `PCM_OFF_PIN, 8'h00);
        per_in.t1_osc_en <= 1'b0;
        // latch drives outputs; a pin-value write lands in the latch
        wr(`PCM_OFF_PIN, 8'hA5);
        rdc("latch wr", `PCM_OFF_LATCH, 8'hA5);
        settle;
        pins(8'hFF, 8'hA5);
        wr(`PCM_OFF_ANS_HI, 8'h03);
        settle;
        pins(8'hFF, 8'hA5);
        rdc("pin out analog", `PCM_OFF_PIN, 8'h24);
        // overrides on bit 5 in priority order
        per_in.ccp_out_en <= 1'b1;
        per_in.ccp_out    <= 1'b0;
        settle;
        pins(8'hFF, 8'h85);
        per_in.pwm_a_en  <= 1'b1;
        per_in.pwm_a_out <= 1'b1;
        settle;
        pins(8'hFF, 8'hA5);
        per_in.pwm_shutdown   <= 1'b1;
        per_in.pwm_a_sd_float <= 1'b1;
        settle;
        chk("pwm float", {31'h0, pin_oe[5]}, 32'h0);
        per_in.pwm_a_en <= 1'b0;
        per_in.pwm_shutdown <= 1'b0;
        wr(`PCM_OFF_DIR, 8'h20);
        settle;
        chk("ccp dir in", {31'h0, pin_oe[5]}, 32'h0);
        // serial data out on bit 7, only while bit 7 is an output
        per_in.ccp_out_en <= 1'b0;
        per_in.spi_en  <= 1'b1;
        per_in.spi_sdo <= 1'b0;
        wr(`PCM_OFF_DIR, 8'h00);
        settle;
        pins(8'hFF, 8'h25);
        wr(`PCM_OFF_DIR, 8'h80);
        settle;
        pins(8'h7F, 8'hA5);
        // a low clock enable freezes the pins until it returns
        ce <= 1'b0;
        per_in.t1_osc_en <= 1'b1;
        settle;
        pins(8'h7F, 8'hA5);
        ce <= 1'b1;
        settle;
        pins(8'h3F, 8'h25);
        complete_run;
    end

endmodule // pcm_port_c_tb
